// File: design/packed_simd_alu.sv
`timescale 1ns/10ps
// Packed add/exchange and bit-probe slice, one registered stage
module packed_simd_alu
	import simd_alu_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic [31:0] first_operand,
	input wire logic [31:0] second_operand,
	input wire logic [31:0] flexible_second_source,
	input wire logic shifter_carry,
	input wire logic shifter_carry_valid,
	input wire logic [3:0] first_operand_reg,
	input wire logic [3:0] dest_reg,
	input wire logic dest_present,
	output logic [31:0] result_r,
	output logic write_en_r,
	output logic [3:0] write_index_r,
	output logic done_r,
	output logic restricted_fault_r,
	output logic flag_n_r,
	output logic flag_z_r,
	output logic flag_c_r,
	output logic flag_v_r
);
	alu_op_t op;
	// Operand halves and lane outputs
	logic [15:0] a_hi;
	logic [15:0] a_lo;
	logic [15:0] b_hi;
	logic [15:0] b_lo;
	logic [15:0] hx_sum;
	logic [15:0] hx_diff;
	logic [15:0] lx_sum;
	logic [15:0] lx_diff;
	logic [31:0] h_sum;
	logic [31:0] h_half;
	logic [31:0] b_sum;
	logic [31:0] b_half;

	// Assembled words ahead of the result select
	logic [31:0] signed_exch_word;
	logic [31:0] add_sub_word;
	logic [31:0] sub_add_word;
	logic [31:0] packed_result;
	logic [31:0] and_value;
	logic [31:0] xor_value;

	// Next values of the three state groups
	logic [31:0] result_nxt;
	logic [3:0] write_index_nxt;
	logic write_en_nxt;
	logic done_nxt;
	logic restricted_fault_nxt;
	logic flag_n_nxt;
	logic flag_z_nxt;
	logic flag_c_nxt;
	logic flag_v_nxt;

	// Decode, index checks and probe flag candidates
	logic is_probe;
	logic illegal_op;
	logic writes_back;
	logic first_is_sp;
	logic first_is_pc;
	logic target_is_sp;
	logic target_is_pc;
	logic bad_reg;
	logic accepted;
	logic [3:0] target_reg;
	logic probe_n;
	logic probe_z;
	logic probe_c;

	probe_if pif ();

	// Operand halves; unknown codes are caught separately
	always_comb begin
		op = alu_op_t'(op_code);
		a_hi = first_operand[31:16];
		a_lo = first_operand[15:0];
		b_hi = second_operand[31:16];
		b_lo = second_operand[15:0];
	end

	// Exchange lanes: first-top with second-bottom, first-bottom with second-top
	lane_adder #(.W(HALF_W)) u_cross_hi (
		.a(a_hi),
		.b(b_lo),
		.sum(hx_sum),
		.diff(hx_diff),
		.half()
	);

	lane_adder #(.W(HALF_W)) u_cross_lo (
		.a(a_lo),
		.b(b_hi),
		.sum(lx_sum),
		.diff(lx_diff),
		.half()
	);

	// Straight halfword lanes, independent carries
	for (genvar i = 0; i < HALF_LANES; i++) begin : g_half
		lane_adder #(.W(HALF_W)) u_lane (
			.a(first_operand[i*HALF_W +: HALF_W]),
			.b(second_operand[i*HALF_W +: HALF_W]),
			.sum(h_sum[i*HALF_W +: HALF_W]),
			.diff(),
			.half(h_half[i*HALF_W +: HALF_W])
		);
	end

	// Straight byte lanes, carries never cross a byte
	for (genvar j = 0; j < BYTE_LANES; j++) begin : g_byte
		lane_adder #(.W(BYTE_W)) u_lane (
			.a(first_operand[j*BYTE_W +: BYTE_W]),
			.b(second_operand[j*BYTE_W +: BYTE_W]),
			.sum(b_sum[j*BYTE_W +: BYTE_W]),
			.diff(),
			.half(b_half[j*BYTE_W +: BYTE_W])
		);
	end

	// Both probe values are formed; the opcode picks which one feeds the flags
	always_comb begin
		and_value = first_operand & flexible_second_source;
		xor_value = first_operand ^ flexible_second_source;
		if (op == OP_BITWISE_XOR_PROBE) begin
			pif.value = xor_value;
		end else begin
			pif.value = and_value;
		end
	end

	probe_flag_unit u_flags (
		.pif(pif)
	);

	// Operation class decode; reserved codes fall in no class
	always_comb begin
		is_probe = (op == OP_BITWISE_AND_PROBE) || (op == OP_BITWISE_XOR_PROBE);
		illegal_op = (op_code > 4'h9);
		// Probes only move flags, so they never claim the write port
		writes_back = !is_probe && !illegal_op;
	end

	// Destination defaults to the first operand register when omitted
	always_comb begin
		target_reg = dest_present ? dest_reg : first_operand_reg;
	end

	// Defensive: the decoder should never send these indices
	always_comb begin
		first_is_sp = (first_operand_reg == STACK_POINTER_IDX);
		first_is_pc = (first_operand_reg == PROGRAM_COUNTER_IDX);
		target_is_sp = (target_reg == STACK_POINTER_IDX);
		target_is_pc = (target_reg == PROGRAM_COUNTER_IDX);
		// Probes write nothing, so only their source index can be wrong
		bad_reg = first_is_sp || first_is_pc
			|| (!is_probe && (target_is_sp || target_is_pc));
		accepted = op_valid && !illegal_op && !bad_reg;
	end

	// Exchange words assembled halfword by halfword before the select
	always_comb begin
		signed_exch_word[31:16] = hx_sum;
		signed_exch_word[15:0] = hx_diff;
		add_sub_word[31:16] = hx_sum;
		add_sub_word[15:0] = lx_diff;
		sub_add_word[31:16] = hx_diff;
		sub_add_word[15:0] = lx_sum;
	end

	// Lane result picked by operation; probes and reserved codes keep the old word
	always_comb begin
		packed_result = result_r;
		unique case (op)
			OP_SIGNED_ADD_SUB_EXCHANGE: begin
				// Sum on top, difference below, one halfword pairing for both
				packed_result = signed_exch_word;
			end
			OP_SIGNED_SUB_ADD_EXCHANGE: begin
				// Same pairing as the add-first form; both codes select signed_exch_word
				packed_result = signed_exch_word;
			end
			OP_UNSIGNED_ADD_SUB_EXCHANGE: begin
				// Low lane subtracts, so its borrow wraps within the halfword
				packed_result = add_sub_word;
			end
			OP_UNSIGNED_SUB_ADD_EXCHANGE: begin
				// High lane subtracts; no borrow reaches the low lane
				packed_result = sub_add_word;
			end
			OP_UNSIGNED_DUAL_HALFWORD_ADD: begin
				// Carry out of each halfword is dropped
				packed_result = h_sum;
			end
			OP_UNSIGNED_QUAD_BYTE_ADD: begin
				// Carry out of each byte is dropped
				packed_result = b_sum;
			end
			OP_UNSIGNED_HALVING_HALFWORD_ADD: begin
				// Carry lands in bit 15 of each halved lane
				packed_result = h_half;
			end
			OP_UNSIGNED_HALVING_BYTE_ADD: begin
				// Carry lands in bit 7 of each halved lane
				packed_result = b_half;
			end
			OP_BITWISE_AND_PROBE, OP_BITWISE_XOR_PROBE: begin
				// Probe value never reaches the register file
				packed_result = result_r;
			end
			default: begin
				// Reserved codes are refused before any write
				packed_result = result_r;
			end
		endcase
	end

	// Probe flag candidates; carry follows the shifter only when it made one
	always_comb begin
		probe_n = pif.neg;
		probe_z = pif.zero;
		probe_c = shifter_carry_valid ? shifter_carry : flag_c_r;
	end

	// Result word and its index change only for accepted work
	always_comb begin
		result_nxt = result_r;
		write_index_nxt = write_index_r;
		if (accepted) begin
			write_index_nxt = target_reg;
		end
		// Probes and refusals leave the last written word on show
		if (accepted && writes_back) begin
			result_nxt = packed_result;
		end
	end

	// Datapath register; holds its word across probes and refusals
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			result_r <= RESULT_RESET;
			write_index_r <= REG_IDX_RESET;
		end else begin
			result_r <= result_nxt;
			write_index_r <= write_index_nxt;
		end
	end

	// One-cycle strobes answer every request, accepted or not
	always_comb begin
		// A refused request still gets its done pulse
		done_nxt = op_valid;
		restricted_fault_nxt = op_valid && (bad_reg || illegal_op);
		write_en_nxt = accepted && writes_back;
	end

	// Strobe register; one cycle high per request, held high across back-to-back requests
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			write_en_r <= 1'b0;
			done_r <= 1'b0;
			restricted_fault_r <= 1'b0;
		end else begin
			write_en_r <= write_en_nxt;
			done_r <= done_nxt;
			restricted_fault_r <= restricted_fault_nxt;
		end
	end

	// Flags are state: only an accepted probe moves them, packed work never does
	always_comb begin
		flag_n_nxt = flag_n_r;
		flag_z_nxt = flag_z_r;
		flag_c_nxt = flag_c_r;
		flag_v_nxt = flag_v_r;
		if (accepted && is_probe) begin
			flag_n_nxt = probe_n;
			flag_z_nxt = probe_z;
			flag_c_nxt = probe_c;
		end
	end

	// Flag register; overflow has no source here, so it keeps its reset level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_n_r <= FLAG_RESET;
			flag_z_r <= FLAG_RESET;
			flag_c_r <= FLAG_RESET;
			flag_v_r <= FLAG_RESET;
		end else begin
			flag_n_r <= flag_n_nxt;
			flag_z_r <= flag_z_nxt;
			flag_c_r <= flag_c_nxt;
			flag_v_r <= flag_v_nxt;
		end
	end
endmodule

// File: inc/simd_alu_pkg.sv
package simd_alu_pkg;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int HALF_LANES = 2;
	localparam int BYTE_LANES = 4;
	localparam int REG_IDX_W = 4;
	localparam int SIGN_BIT = 31;
	localparam logic [3:0] STACK_POINTER_IDX = 4'hD;
	localparam logic [3:0] PROGRAM_COUNTER_IDX = 4'hF;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
	localparam logic [3:0] REG_IDX_RESET = 4'h0;
	localparam logic FLAG_RESET = 1'b0;

	// Operation select codes on the op_code port
	typedef enum logic [3:0] {
		OP_SIGNED_ADD_SUB_EXCHANGE = 4'h0,
		OP_SIGNED_SUB_ADD_EXCHANGE = 4'h1,
		OP_BITWISE_AND_PROBE = 4'h2,
		OP_BITWISE_XOR_PROBE = 4'h3,
		OP_UNSIGNED_DUAL_HALFWORD_ADD = 4'h4,
		OP_UNSIGNED_QUAD_BYTE_ADD = 4'h5,
		OP_UNSIGNED_ADD_SUB_EXCHANGE = 4'h6,
		OP_UNSIGNED_SUB_ADD_EXCHANGE = 4'h7,
		OP_UNSIGNED_HALVING_HALFWORD_ADD = 4'h8,
		OP_UNSIGNED_HALVING_BYTE_ADD = 4'h9
	} alu_op_t;
endpackage

// File: inc/probe_if.sv
`timescale 1ns/10ps
// Carries the probe value to the flag evaluator and its sign and zero back
interface probe_if;
	logic [31:0] value;
	logic neg;
	logic zero;
	modport alu (output value, input neg, input zero);
	modport unit (input value, output neg, output zero);
endinterface

// File: design/lane_adder.sv
`timescale 1ns/10ps
// One lane: truncated sum, truncated difference and halved sum
module lane_adder #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	output logic [W-1:0] sum,
	output logic [W-1:0] diff,
	output logic [W-1:0] half
);
	logic [W:0] wide_sum;

	// Extra bit keeps the carry so halving loses nothing
	always_comb begin
		wide_sum = {1'b0, a} + {1'b0, b};
		sum = wide_sum[W-1:0];
		diff = a - b;
		half = wide_sum[W:1];
	end
endmodule

// File: design/probe_flag_unit.sv
`timescale 1ns/10ps
// Sign and zero of a discarded probe result
module probe_flag_unit
	import simd_alu_pkg::*;
(
	probe_if.unit pif
);
	// Sign from top bit, zero only for all-clear value
	always_comb begin
		pif.neg = pif.value[SIGN_BIT];
		pif.zero = (pif.value == 32'h0000_0000);
	end
endmodule

// File: testbench/packed_simd_alu_asserts.sv
`timescale 1ns/10ps
// Port-level timing and flag checks for the slice
module packed_simd_alu_asserts
	import simd_alu_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic [31:0] first_operand,
	input wire logic [31:0] flexible_second_source,
	input wire logic [3:0] first_operand_reg,
	input wire logic dest_present,
	input wire logic write_en_r,
	input wire logic [3:0] write_index_r,
	input wire logic done_r,
	input wire logic restricted_fault_r,
	input wire logic flag_n_r,
	input wire logic flag_z_r,
	input wire logic flag_c_r,
	input wire logic flag_v_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Probe values; sampled one cycle back by the flag checks
	wire and_z = (first_operand & flexible_second_source) == 32'h0;
	wire and_n = first_operand[31] & flexible_second_source[31];
	wire xor_z = first_operand == flexible_second_source;
	wire xor_n = first_operand[31] ^ flexible_second_source[31];
	// A probe on a register the slice accepts
	sequence probe_s(logic [3:0] c);
		op_valid && op_code == c && first_operand_reg != 4'hD && first_operand_reg != 4'hF;
	endsequence
	done_pulse_a: assert property (op_valid |=> done_r) else $error("done missing");
	idle_quiet_a: assert property (!op_valid |=> !done_r && !write_en_r && !restricted_fault_r)
		else $error("pulse without request");
	and_probe_a: assert property (probe_s(4'h2) |=> !write_en_r && flag_z_r == $past(and_z) && flag_n_r == $past(and_n)) else $error("and probe flags");
	xor_probe_a: assert property (probe_s(4'h3) |=> !write_en_r && flag_z_r == $past(xor_z) && flag_n_r == $past(xor_n)) else $error("xor probe flags");
	overflow_kept_a: assert property (!flag_v_r) else $error("overflow moved");
	flags_kept_a: assert property (op_valid && op_code inside {0, 1, [4:9]} |=> $stable({flag_n_r, flag_z_r, flag_c_r})) else $error("packed op moved flags");
	fault_pc_a: assert property (op_valid && first_operand_reg == 4'hF |=> restricted_fault_r && !write_en_r) else $error("restricted index taken");
	dest_default_a: assert property (op_valid && op_code == 4'h4 && !dest_present && first_operand_reg < 4'hD |=> write_en_r && write_index_r == $past(first_operand_reg)) else $error("default target");
endmodule

// File: testbench/reg_file_model.sv
`timescale 1ns/10ps
// Register file side: keeps what the slice writes back
module reg_file_model (
	input wire logic clk,
	input wire logic we,
	input wire logic [3:0] idx,
	input wire logic [31:0] data
);
	logic [31:0] mem [16];
	// Write port; stack pointer and program counter never written
	always @(posedge clk) if (we && idx != 4'hD && idx != 4'hF) mem[idx] <= data;
endmodule

// File: testbench/tb_packed_simd_alu.sv
`timescale 1ns/10ps
// Random and corner requests checked against a lane model
module tb_packed_simd_alu;
	logic clk = 0, rstn = 0, op_valid = 0, shifter_carry = 0, shifter_carry_valid = 0;
	logic dest_present = 0, write_en_r, done_r, restricted_fault_r;
	logic flag_n_r, flag_z_r, flag_c_r, flag_v_r;
	logic [3:0] op_code = 0, first_operand_reg = 0, dest_reg = 0, write_index_r;
	logic [31:0] first_operand = 0, second_operand = 0, result_r;
	integer seed = 22, n_errors = 0, checked = 0, cyc = 0;
	logic pend = 1'b0;
	logic [3:0] pend_idx = 4'h0;
	logic [31:0] pend_val = 32'h0;
	packed_simd_alu packed_simd_alu_i (.clk, .rstn, .op_valid, .op_code, .first_operand,
		.second_operand, .flexible_second_source(second_operand), .shifter_carry,
		.shifter_carry_valid, .first_operand_reg, .dest_reg, .dest_present, .result_r,
		.write_en_r, .write_index_r, .done_r, .restricted_fault_r, .flag_n_r, .flag_z_r,
		.flag_c_r, .flag_v_r);
	reg_file_model reg_file_model_i (.clk, .we(write_en_r), .idx(write_index_r), .data(result_r));
	always #20 clk = ~clk;
	// Hang guard, far above the planned run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// A write lands one edge after write_en_r rises, so its check waits a cycle
	task automatic check_stored;
		if (pend) cmp("stored", pend_val, reg_file_model_i.mem[pend_idx]);
	endtask
	// Lane model; sums kept one bit wider before halving
	function automatic logic [31:0] model(input logic [3:0] op, input logic [31:0] x, y);
		logic [15:0] xh, xl, yh, yl;
		logic [16:0] p, q;
		logic [8:0] s;
		logic [31:0] r;
		{xh, xl} = x;
		{yh, yl} = y;
		p = {1'b0, xh} + yh;
		q = {1'b0, xl} + yl;
		for (int i = 0; i < 32; i += 8) begin
			s = {1'b0, x[i+:8]} + y[i+:8];
			r[i+:8] = op == 4'h5 ? s[7:0] : s[8:1];
		end
		case (op)
			4'h0, 4'h1: return {xh + yl, xh - yl};
			4'h4: return {p[15:0], q[15:0]};
			4'h6: return {xh + yl, xl - yh};
			4'h7: return {xh - yl, xl + yh};
			4'h8: return {p[16:1], q[16:1]};
			default: return r;
		endcase
	endfunction
	// One request set on a falling edge, checked at the next one
	task automatic run(input logic [3:0] op, rn, rd, input logic dp, input logic [31:0] x, y);
		logic [31:0] e, p;
		logic [2:0] fl, ef;
		logic [3:0] t;
		logic ok, pr;
		op_valid = 1;
		op_code = op;
		first_operand_reg = rn;
		dest_reg = rd;
		dest_present = dp;
		first_operand = x;
		second_operand = y;
		{shifter_carry, shifter_carry_valid} = 2'($random(seed));
		fl = {flag_n_r, flag_z_r, flag_c_r};
		t = dp ? rd : rn;
		pr = op == 4'h2 || op == 4'h3;
		p = op == 4'h2 ? x & y : x ^ y;
		ok = op < 4'hA && rn != 4'hD && rn != 4'hF && (pr || (t != 4'hD && t != 4'hF));
		ef = ok && pr ? {p[31], p == 0, shifter_carry_valid ? shifter_carry : fl[0]} : fl;
		e = ok && !pr ? model(op, x, y) : result_r;
		@(negedge clk);
		cmp("done", 1, done_r);
		cmp("fault", !ok, restricted_fault_r);
		cmp("write", ok && !pr, write_en_r);
		cmp("flags", ef, {flag_n_r, flag_z_r, flag_c_r});
		cmp("result", e, result_r);
		check_stored;
		pend = ok && !pr;
		pend_idx = t;
		pend_val = e;
	endtask
	// Main sequence, requests back to back
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1;
		for (int i = 0; i < 11; i++) run(4'(i), 4'h1, 4'h2, i[0], $random(seed), $random(seed));
		$display("Test codes done");
		run(4'h8, 4'h3, 4'h4, 1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		run(4'h9, 4'h3, 4'h4, 0, 32'hFFFF_FFFF, 32'h0101_0101);
		run(4'h5, 4'h3, 4'h4, 1, 32'hFF80_FF01, 32'h0180_0101);
		run(4'h2, 4'hE, 4'h0, 0, 32'h0000_0000, 32'hFFFF_FFFF);
		run(4'h3, 4'h5, 4'h0, 0, 32'h8000_1234, 32'h8000_1234);
		$display("Test corners done");
		run(4'h4, 4'hF, 4'h2, 1, 32'h1, 32'h1);
		run(4'h6, 4'h1, 4'hD, 1, 32'h1, 32'h1);
		run(4'h7, 4'hD, 4'h0, 0, 32'h1, 32'h1);
		run(4'h3, 4'hF, 4'h0, 0, 32'h1, 32'h1);
		$display("Test refusals done");
		repeat (200) run(4'({$random(seed)} % 11), 4'({$random(seed)} % 13),
			4'({$random(seed)} % 13), 1'($random(seed)), $random(seed), $random(seed));
		$display("Test random done");
		op_valid = 0;
		@(negedge clk);
		check_stored;
		wrap_up;
	end
endmodule
bind packed_simd_alu packed_simd_alu_asserts packed_simd_alu_asserts_i (.clk, .rstn, .op_valid,
	.op_code, .first_operand, .flexible_second_source, .first_operand_reg, .dest_present,
	.write_en_r, .write_index_r, .done_r, .restricted_fault_r, .flag_n_r, .flag_z_r, .flag_c_r,
	.flag_v_r);
